// ==== pma_regs.vh ====
// Constants for the programmable macrocell array
`ifndef PMA_REGS_VH
`define PMA_REGS_VH
`define PMA_MASK_RESET    8'h00
`define PMA_STATE_RESET   8'h00
`define PMA_FF_D          2'h0
`define PMA_FF_T          2'h1
`define PMA_FF_JK         2'h2
`define PMA_FF_SR         2'h3
`define PMA_IN_PASS       2'h0
`define PMA_IN_LATCH      2'h1
`define PMA_IN_REG        2'h2
`define PMA_SEL_OUT_STATE 2'h0
`define PMA_SEL_MASK      2'h1
`define PMA_SEL_IN_READ   2'h2
`define PMA_NIB_LO        4
`define PMA_CELLS         8
`endif

// ==== pma_macrocell_array.v ====
// Output and input macrocells of the complex logic array
// Summary of operation
// RQ1: Three external chip selects come straight from product terms, using no output cell.
// RQ2: Group one drives Port A or B, group two drives Port B or C.
// RQ3: Summed terms pass XOR polarity, mux picks registered or combinational, feeds back.
// RQ4: Each output cell flip-flop acts as D, T, JK or SR type.
// RQ5: Output cell clock is a product term or the external cell clock.
// RQ6: Output cell flip-flop updates on rising edge of its selected clock.
// RQ7: Preset and clear are active high; clear is OR of up to two terms.
// RQ8: Term budgets: group one 3+6, group two cells 0-3 4+5, 4-7 4+6.
// RQ9: A consumed term serves one cell only; borrowing only from neighbours.
// RQ10: Equations needing more terms expand through extra cells, adding delay.
// RQ11: Host loads and reads all sixteen output cells; cell n is data bit n.
// RQ12: Host load overrides preset, clear and clock of the cell.
// RQ13: Edge loading on trailing write strobe edge, level loading while strobe active.
// RQ14: Each group has an 8-bit write mask, reset 00h, one blocks writes.
// RQ15: Pin output enable is one product term ORed with direction register.
// RQ16: Logic output with no enable equation is driven from power up.
// RQ17: Internal node cell releases its pin but still feeds the array.
// RQ18: 24 input cells, one per pin, as latch, register or pass-through.
// RQ19: Input cell enable or clock is a product term or address strobe.
// RQ20: One control term per nibble, each serving four input cells.
// RQ21: Host reads input cell outputs through a dedicated read buffer.
// RQ22: Input cells can capture address bits above A15 with the address strobe.
// RQ23: Register-mode input cells capture on rising edge of their selected clock.
`include "pma_regs.vh"
module pma_macrocell_array (
  input  wire        REF_CLK_IN,
  input  wire        SRST_IN,
  input  wire [63:0] SUM_TERMS_IN,
  input  wire [31:0] J_K_TERMS_IN,
  input  wire [15:0] CLK_TERMS_IN,
  input  wire [15:0] PRESET_TERMS_IN,
  input  wire [31:0] CLEAR_TERMS_IN,
  input  wire [15:0] OE_TERMS_IN,
  input  wire [2:0]  CHIP_SEL_TERMS_IN,
  input  wire        EXTERNAL_CELL_CLOCK_IN,
  input  wire [31:0] CELL_FF_TYPE_IN,
  input  wire [15:0] CELL_XOR_INV_IN,
  input  wire [15:0] CELL_REGISTERED_IN,
  input  wire [15:0] CELL_CLK_EXT_IN,
  input  wire [15:0] CELL_PORT_HIGH_IN,
  input  wire [15:0] CELL_INTERNAL_NODE_IN,
  input  wire [15:0] CELL_OE_EQN_DEF_IN,
  input  wire [23:0] PORT_DIR_IN,
  input  wire        LOAD_LEVEL_MODE_IN,
  input  wire [23:0] PORT_PINS_IN,
  input  wire [47:0] IN_CELL_MODE_IN,
  input  wire [5:0]  IN_CELL_CTRL_TERMS_IN,
  input  wire [5:0]  IN_CELL_USE_STROBE_IN,
  input  wire        ADDRESS_LATCH_STROBE_IN,
  input  wire        HOST_SEL_IN,
  input  wire [1:0]  HOST_REG_SEL_IN,
  input  wire        HOST_GROUP_IN,
  input  wire [1:0]  HOST_IN_PORT_IN,
  input  wire        HOST_WR_IN,
  input  wire        HOST_RD_IN,
  input  wire [7:0]  HOST_DATA_IN,
  output reg  [7:0]  HOST_DATA_OUT,
  output wire        HOST_DATA_OE_OUT,
  output wire [23:0] PORT_PINS_OUT,
  output wire [23:0] PORT_PINS_OE_OUT,
  output wire [15:0] CELL_FEEDBACK_OUT,
  output wire [23:0] INPUT_BUS_OUT,
  output wire [2:0]  CHIP_SELECT_OUT
);

  // Cell index i: 0-7 group one, 8-15 group two; bit n of a group is data bit n
  reg  [15:0] cell_ff;
  reg  [15:0] prev_clk_ff;
  reg  [7:0]  mask_one_ff;
  reg  [7:0]  mask_two_ff;
  reg         wr_prev_ff;
  reg  [7:0]  wr_data_ff;
  reg         wr_group_ff;
  reg         wr_cell_ff;
  reg  [23:0] in_cell_ff;
  reg  [5:0]  in_prev_ctrl_ff;
  reg  [15:0] nxt_cell;
  wire [15:0] sum_xor;
  wire [15:0] cell_clk;
  wire [15:0] clk_rise;
  wire [15:0] cell_result;
  wire [15:0] host_load;
  wire [15:0] host_val;
  wire [5:0]  in_ctrl;
  reg  [23:0] in_cell_out;
  wire        wr_cell;
  wire        wr_trail;
  integer     k;
  integer     n;
  integer     m;
  wire [15:0] lvl_load;
  wire [15:0] edge_load;
  wire [23:0] in_en;
  wire [7:0]  in_read_byte;

  // Next state of one flip-flop for its configured type
  function ff_next;
    input [1:0] ff_type;
    input       q;
    input       d;
    input       jk_k;
    begin
      case (ff_type)
        `PMA_FF_D:  ff_next = d;
        `PMA_FF_T:  ff_next = q ^ d;
        `PMA_FF_JK: ff_next = (d & ~q) | (~jk_k & q);
        `PMA_FF_SR: ff_next = d | (~jk_k & q);
        default:    ff_next = q;
      endcase
    end
  endfunction

  // Selects the controlling nibble of an input cell
  function [2:0] nib_idx;
    input integer bit_n;
    integer       quot;
    begin
      quot    = bit_n / `PMA_NIB_LO;
      nib_idx = quot[2:0];
    end
  endfunction

  // Group of an output cell: 0 for cells 0-7, 1 for cells 8-15
  function cell_group;
    input integer cell_n;
    begin
      cell_group = (cell_n >= `PMA_CELLS);
    end
  endfunction

  // Write-block bit of one output cell, taken from its group's mask
  function mask_bit;
    input integer cell_n;
    input [7:0]   mask_lo;
    input [7:0]   mask_hi;
    integer       pos;
    begin
      pos = cell_n % `PMA_CELLS;
      if (cell_group(cell_n)) begin
        mask_bit = mask_hi[pos];
      end else begin
        mask_bit = mask_lo[pos];
      end
    end
  endfunction

  // Input cell byte of one port; a port code beyond C reads zero
  function [7:0] port_byte;
    input [1:0]  port_sel;
    input [23:0] bus;
    begin
      case (port_sel)
        2'h0:    port_byte = bus[7:0];
        2'h1:    port_byte = bus[15:8];
        2'h2:    port_byte = bus[23:16];
        default: port_byte = 8'h00;
      endcase
    end
  endfunction

  // Chip selects are pure product terms, no output cell involved
  assign CHIP_SELECT_OUT = CHIP_SEL_TERMS_IN; // [RQ1]

  assign wr_cell  = HOST_SEL_IN & (HOST_REG_SEL_IN == `PMA_SEL_OUT_STATE);
  assign wr_trail = wr_prev_ff & ~HOST_WR_IN; // [RQ13]

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_out
      // Term budgets and borrowing are resolved when terms are placed; the cell sees the summed result
      assign sum_xor[g] = (|SUM_TERMS_IN[g*4 +: 4]) ^ CELL_XOR_INV_IN[g]; // [RQ3] [RQ8] [RQ9] [RQ10]
      assign cell_clk[g] = CELL_CLK_EXT_IN[g] ? EXTERNAL_CELL_CLOCK_IN : CLK_TERMS_IN[g]; // [RQ5]
      // Clocks are sampled, so a clock pulse that spans no rising REF_CLK_IN edge is missed
      assign clk_rise[g] = cell_clk[g] & ~prev_clk_ff[g]; // [RQ6]
      assign cell_result[g] = CELL_REGISTERED_IN[g] ? cell_ff[g] : sum_xor[g]; // [RQ3]
      // Level loading tracks the bus on every cycle while the strobe is high
      assign lvl_load[g]  = HOST_WR_IN & wr_cell & (HOST_GROUP_IN == cell_group(g)); // [RQ13]
      assign edge_load[g] = wr_trail & wr_cell_ff & (wr_group_ff == cell_group(g)); // [RQ13]
      // A set mask bit silently drops the load for its cell
      assign host_load[g] = (LOAD_LEVEL_MODE_IN ? lvl_load[g] : edge_load[g])
                            & ~mask_bit(g, mask_one_ff, mask_two_ff); // [RQ13] [RQ14]
      assign host_val[g] = LOAD_LEVEL_MODE_IN ? HOST_DATA_IN[g % 8] : wr_data_ff[g % 8]; // [RQ11]
    end
  endgenerate

  // Host load beats preset, preset beats clear, clear beats the clock
  always @* begin
    for (k = 0; k < 16; k = k + 1) begin
      if (host_load[k]) begin
        nxt_cell[k] = host_val[k]; // [RQ12]
      end else if (PRESET_TERMS_IN[k]) begin
        nxt_cell[k] = 1'b1; // [RQ7]
      end else if (CLEAR_TERMS_IN[2*k] | CLEAR_TERMS_IN[2*k+1]) begin
        nxt_cell[k] = 1'b0; // [RQ7]
      end else if (clk_rise[k]) begin
        nxt_cell[k] = ff_next(CELL_FF_TYPE_IN[2*k +: 2], cell_ff[k], sum_xor[k], J_K_TERMS_IN[2*k]); // [RQ4]
      end else begin
        nxt_cell[k] = cell_ff[k];
      end
    end
  end

  // Output cell flip-flops and their clock edge detectors
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      cell_ff     <= {2{`PMA_STATE_RESET}};
      prev_clk_ff <= 16'h0000;
    end else begin
      cell_ff     <= nxt_cell;
      prev_clk_ff <= cell_clk;
    end
  end

  // Edge loading captures data, group and target on each cycle the strobe is high,
  // so the bus may change as the strobe ends without tearing the load
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      wr_prev_ff  <= 1'b0;
      wr_data_ff  <= 8'h00;
      wr_group_ff <= 1'b0;
      wr_cell_ff  <= 1'b0;
    end else begin
      wr_prev_ff <= HOST_WR_IN;
      if (HOST_WR_IN) begin
        wr_data_ff  <= HOST_DATA_IN;
        wr_group_ff <= HOST_GROUP_IN;
        wr_cell_ff  <= wr_cell;
      end
    end
  end

  // Write-block masks, one per group
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      mask_one_ff <= `PMA_MASK_RESET; // [RQ14]
      mask_two_ff <= `PMA_MASK_RESET;
    end else if (HOST_WR_IN & HOST_SEL_IN & (HOST_REG_SEL_IN == `PMA_SEL_MASK)) begin
      if (HOST_GROUP_IN) begin
        mask_two_ff <= HOST_DATA_IN;
      end else begin
        mask_one_ff <= HOST_DATA_IN;
      end
    end
  end

  // Pins: A = 0-7, B = 8-15, C = 16-23
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      wire a_on = ~CELL_INTERNAL_NODE_IN[g] & ~CELL_PORT_HIGH_IN[g];
      wire b1   = ~CELL_INTERNAL_NODE_IN[g] & CELL_PORT_HIGH_IN[g];
      wire b2   = ~CELL_INTERNAL_NODE_IN[g+8] & ~CELL_PORT_HIGH_IN[g+8];
      wire c_on = ~CELL_INTERNAL_NODE_IN[g+8] & CELL_PORT_HIGH_IN[g+8];
      wire oe1  = ~CELL_OE_EQN_DEF_IN[g] | OE_TERMS_IN[g]; // [RQ16]
      wire oe2  = ~CELL_OE_EQN_DEF_IN[g+8] | OE_TERMS_IN[g+8];
      // Internal-node cells leave their pin to other I/O functions
      assign PORT_PINS_OUT[g]       = a_on & cell_result[g]; // [RQ2] [RQ17]
      assign PORT_PINS_OE_OUT[g]    = (a_on & oe1) | PORT_DIR_IN[g]; // [RQ15]
      assign PORT_PINS_OUT[g+8]     = (b1 & cell_result[g]) | (b2 & cell_result[g+8]); // [RQ2]
      assign PORT_PINS_OE_OUT[g+8]  = (b1 & oe1) | (b2 & oe2) | PORT_DIR_IN[g+8]; // [RQ15]
      assign PORT_PINS_OUT[g+16]    = c_on & cell_result[g+8]; // [RQ2]
      assign PORT_PINS_OE_OUT[g+16] = (c_on & oe2) | PORT_DIR_IN[g+16]; // [RQ15]
    end
  endgenerate

  assign CELL_FEEDBACK_OUT = cell_result; // [RQ3] [RQ17]

  // Input cells: one control per nibble, term or address strobe
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_ctrl
      assign in_ctrl[g] = IN_CELL_USE_STROBE_IN[g] ? ADDRESS_LATCH_STROBE_IN : IN_CELL_CTRL_TERMS_IN[g]; // [RQ19] [RQ20]
    end
    for (g = 0; g < 24; g = g + 1) begin : g_in
      assign in_en[g] = in_ctrl[nib_idx(g)]; // [RQ20]
    end
  endgenerate

  // Latch mode follows the pin while enabled; register mode captures on the rising enable
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      in_cell_ff      <= 24'h000000;
      in_prev_ctrl_ff <= 6'h00;
    end else begin
      in_prev_ctrl_ff <= in_ctrl;
      for (n = 0; n < 24; n = n + 1) begin
        if (IN_CELL_MODE_IN[2*n +: 2] == `PMA_IN_LATCH && in_en[n]) begin
          in_cell_ff[n] <= PORT_PINS_IN[n]; // [RQ18] [RQ22]
        end else if (IN_CELL_MODE_IN[2*n +: 2] == `PMA_IN_REG && in_en[n] && !in_prev_ctrl_ff[nib_idx(n)]) begin
          in_cell_ff[n] <= PORT_PINS_IN[n]; // [RQ23] [RQ22]
        end
      end
    end
  end

  // An open latch is transparent, so the bus sees the pin in the same cycle
  always @* begin
    for (m = 0; m < 24; m = m + 1) begin
      if (IN_CELL_MODE_IN[2*m +: 2] == `PMA_IN_PASS) begin
        in_cell_out[m] = PORT_PINS_IN[m]; // [RQ18]
      end else if (IN_CELL_MODE_IN[2*m +: 2] == `PMA_IN_LATCH && in_en[m]) begin
        in_cell_out[m] = PORT_PINS_IN[m]; // [RQ18]
      end else begin
        in_cell_out[m] = in_cell_ff[m];
      end
    end
  end

  assign INPUT_BUS_OUT = in_cell_out;

  // Host read data, registered
  assign HOST_DATA_OE_OUT = HOST_SEL_IN & HOST_RD_IN;
  assign in_read_byte     = port_byte(HOST_IN_PORT_IN, in_cell_out); // [RQ21]
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      HOST_DATA_OUT <= 8'h00;
    end else if (HOST_SEL_IN & HOST_RD_IN) begin
      case (HOST_REG_SEL_IN)
        `PMA_SEL_OUT_STATE: HOST_DATA_OUT <= HOST_GROUP_IN ? cell_ff[15:8] : cell_ff[7:0]; // [RQ11]
        `PMA_SEL_MASK:      HOST_DATA_OUT <= HOST_GROUP_IN ? mask_two_ff : mask_one_ff;
        `PMA_SEL_IN_READ:   HOST_DATA_OUT <= in_read_byte; // [RQ21]
        default:            HOST_DATA_OUT <= 8'h00;
      endcase
    end
  end

endmodule // pma_macrocell_array

// ==== pma_checker.sv ====
// Port-level assertions for the macrocell array
module pma_checker (
  input wire logic        REF_CLK_IN,
  input wire logic        SRST_IN,
  input wire logic [2:0]  CHIP_SEL_TERMS_IN,
  input wire logic [2:0]  CHIP_SELECT_OUT,
  input wire logic        HOST_SEL_IN,
  input wire logic        HOST_RD_IN,
  input wire logic [1:0]  HOST_REG_SEL_IN,
  input wire logic [1:0]  HOST_IN_PORT_IN,
  input wire logic [7:0]  HOST_DATA_OUT,
  input wire logic        HOST_DATA_OE_OUT,
  input wire logic [47:0] IN_CELL_MODE_IN,
  input wire logic [23:0] PORT_PINS_IN,
  input wire logic [23:0] INPUT_BUS_OUT,
  input wire logic [63:0] SUM_TERMS_IN,
  input wire logic [15:0] CELL_XOR_INV_IN,
  input wire logic [15:0] CELL_REGISTERED_IN,
  input wire logic [15:0] CELL_FEEDBACK_OUT,
  input wire logic [15:0] CELL_OE_EQN_DEF_IN,
  input wire logic [15:0] CELL_INTERNAL_NODE_IN,
  input wire logic [15:0] CELL_PORT_HIGH_IN,
  input wire logic [15:0] OE_TERMS_IN,
  input wire logic [23:0] PORT_DIR_IN,
  input wire logic [23:0] PORT_PINS_OE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  a_chip_sel_pass: assert property (CHIP_SELECT_OUT == CHIP_SEL_TERMS_IN)
    else $error("chip select differs from its terms");
  a_read_drive_on: assert property (HOST_DATA_OE_OUT == (HOST_SEL_IN && HOST_RD_IN))
    else $error("data bus drive wrong");
  a_input_read_path: assert property (HOST_SEL_IN && HOST_RD_IN && HOST_REG_SEL_IN == 2'h2 && HOST_IN_PORT_IN == 2'h2
    |=> HOST_DATA_OUT == $past(INPUT_BUS_OUT[23:16])) else $error("input cell read wrong");
  a_pass_through: assert property (IN_CELL_MODE_IN == '0 |-> INPUT_BUS_OUT == PORT_PINS_IN)
    else $error("pass mode input bus wrong");
  a_comb_cell_top: assert property (!CELL_REGISTERED_IN[15]
    |-> CELL_FEEDBACK_OUT[15] == ((|SUM_TERMS_IN[63:60]) ^ CELL_XOR_INV_IN[15])) else $error("combinational path wrong");
  a_oe_default_on: assert property (CELL_OE_EQN_DEF_IN == '0 && CELL_INTERNAL_NODE_IN == '0 && CELL_PORT_HIGH_IN == '0
    |-> PORT_PINS_OE_OUT[15:0] == 16'hffff) else $error("default enable missing");
  a_oe_or_terms: assert property (CELL_OE_EQN_DEF_IN == '1 && CELL_INTERNAL_NODE_IN == '0 && CELL_PORT_HIGH_IN == '0
    |-> PORT_PINS_OE_OUT[15:0] == (OE_TERMS_IN | PORT_DIR_IN[15:0])) else $error("enable term or wrong");
  a_node_release: assert property (CELL_INTERNAL_NODE_IN == '1 && PORT_DIR_IN == '0 && OE_TERMS_IN == '0
    |-> PORT_PINS_OE_OUT[15:0] == 16'h0000) else $error("internal node drives pin");
endmodule // pma_checker

bind pma_macrocell_array pma_checker chk (.*);

// ==== pma_host_model.sv ====
// Host microcontroller model driving the register access lines
module pma_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            sel_out,
  output logic [1:0]      reg_sel_out,
  output logic            group_out,
  output logic [1:0]      in_port_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sel_out, reg_sel_out, group_out, in_port_out, wr_out, rd_out, wdata_out} = '0;
  // Strobe high one cycle, selection held past its trailing edge
  task automatic wr(input logic [1:0] rs, input logic g, input logic [7:0] d);
    @(negedge clk_in);
    {sel_out, reg_sel_out, group_out, wr_out, wdata_out} = {1'b1, rs, g, 1'b1, d};
    @(negedge clk_in);
    wr_out = 1'b0;
    @(negedge clk_in);
    sel_out = 1'b0;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [1:0] rs, input logic [1:0] p, output logic [7:0] d);
    @(negedge clk_in);
    {sel_out, reg_sel_out, group_out, in_port_out, rd_out} = {1'b1, rs, p[0], p, 1'b1};
    @(negedge clk_in);
    {sel_out, rd_out} = 2'b00;
    d = rdata_in;
  endtask
endmodule // pma_host_model

// ==== pma_tb.sv ====
// Self-checking testbench for the macrocell array
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK_IN = 0, SRST_IN = 1, EXTERNAL_CELL_CLOCK_IN = 0, LOAD_LEVEL_MODE_IN = 0, ADDRESS_LATCH_STROBE_IN = 0;
  logic [63:0] SUM_TERMS_IN = '0;
  logic [31:0] J_K_TERMS_IN = '0, CLEAR_TERMS_IN = '0, CELL_FF_TYPE_IN = '0;
  logic [15:0] CLK_TERMS_IN = '0, PRESET_TERMS_IN = '0, OE_TERMS_IN = '0, CELL_XOR_INV_IN = '0, CELL_REGISTERED_IN = '1;
  logic [15:0] CELL_CLK_EXT_IN = '1, CELL_PORT_HIGH_IN = '0, CELL_INTERNAL_NODE_IN = '0, CELL_OE_EQN_DEF_IN = '1;
  logic [15:0] CELL_FEEDBACK_OUT;
  logic [23:0] PORT_DIR_IN = '0, PORT_PINS_IN = '0, PORT_PINS_OUT, PORT_PINS_OE_OUT, INPUT_BUS_OUT;
  logic [47:0] IN_CELL_MODE_IN = '0;
  logic [5:0]  IN_CELL_CTRL_TERMS_IN = '0, IN_CELL_USE_STROBE_IN = '0;
  logic [2:0]  CHIP_SEL_TERMS_IN = '0, CHIP_SELECT_OUT;
  logic        HOST_SEL_IN, HOST_GROUP_IN, HOST_WR_IN, HOST_RD_IN, HOST_DATA_OE_OUT;
  logic [1:0]  HOST_REG_SEL_IN, HOST_IN_PORT_IN;
  logic [7:0]  HOST_DATA_IN, HOST_DATA_OUT, rv;
  int          errors = 0, compares = 0;
  always #4 REF_CLK_IN = ~REF_CLK_IN;
  pma_macrocell_array uut (.*);
  pma_host_model host (.clk_in(REF_CLK_IN), .rdata_in(HOST_DATA_OUT), .sel_out(HOST_SEL_IN),
    .reg_sel_out(HOST_REG_SEL_IN), .group_out(HOST_GROUP_IN), .in_port_out(HOST_IN_PORT_IN),
    .wr_out(HOST_WR_IN), .rd_out(HOST_RD_IN), .wdata_out(HOST_DATA_IN));
  task automatic report_and_stop;
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge REF_CLK_IN);
  endtask
  task automatic rdchk(input string n, input logic [1:0] rs, input logic [1:0] p, input logic [7:0] e);
    host.rd(rs, p, rv);
    `CHK(n, e, rv)
  endtask
  initial begin
    repeat (5000) @(posedge REF_CLK_IN);
    errors++;
    report_and_stop;
  end
  initial begin
    tick(10);
    SRST_IN = 0;
    rdchk("cells reset", 2'h0, 2'h0, 8'h00);
    rdchk("mask one", 2'h1, 2'h0, 8'h00);
    rdchk("mask two", 2'h1, 2'h1, 8'h00);
    host.wr(2'h0, 1'b0, 8'h55);
    host.wr(2'h0, 1'b1, 8'ha3);
    rdchk("cells one", 2'h0, 2'h0, 8'h55);
    rdchk("cells two", 2'h0, 2'h1, 8'ha3);
    `CHK("pins low", 16'ha355, PORT_PINS_OUT[15:0])
    CELL_PORT_HIGH_IN = '1;
    tick(1);
    `CHK("pins high", 16'ha355, PORT_PINS_OUT[23:8])
    host.wr(2'h1, 1'b0, 8'h0f);
    host.wr(2'h0, 1'b0, 8'hff);
    rdchk("masked", 2'h0, 2'h0, 8'hf5);
    host.wr(2'h1, 1'b0, 8'h00);
    LOAD_LEVEL_MODE_IN = 1;
    host.wr(2'h0, 1'b0, 8'h3c);
    rdchk("level load", 2'h0, 2'h0, 8'h3c);
    rdchk("unmapped", 2'h3, 2'h0, 8'h00);
    {OE_TERMS_IN, PORT_DIR_IN, CELL_PORT_HIGH_IN} = {16'h000f, 24'h0000f0, 16'h0000};
    tick(1);
    `CHK("oe terms", 16'h00ff, PORT_PINS_OE_OUT[15:0])
    CELL_OE_EQN_DEF_IN = '0;
    tick(1);
    `CHK("oe default", 16'hffff, PORT_PINS_OE_OUT[15:0])
    {CELL_INTERNAL_NODE_IN, PORT_DIR_IN, OE_TERMS_IN} = {16'hffff, 24'h0, 16'h0};
    tick(1);
    `CHK("oe node", 16'h0000, PORT_PINS_OE_OUT[15:0])
    `CHK("node feedback", 16'ha33c, CELL_FEEDBACK_OUT)
    {SUM_TERMS_IN, CELL_XOR_INV_IN} = {64'hffff_ffff_ffff_ffff, 16'h00ff};
    EXTERNAL_CELL_CLOCK_IN = 1;
    tick(3);
    EXTERNAL_CELL_CLOCK_IN = 0;
    tick(3);
    `CHK("d type", 16'hff00, CELL_FEEDBACK_OUT)
    {CELL_FF_TYPE_IN, CELL_XOR_INV_IN, CELL_CLK_EXT_IN} = {{16{2'h1}}, 16'h0f0f, 16'h0000};
    CLK_TERMS_IN = '1;
    tick(3);
    CLK_TERMS_IN = '0;
    tick(3);
    `CHK("t type", 16'h0ff0, CELL_FEEDBACK_OUT)
    CELL_REGISTERED_IN = 16'h00ff;
    tick(1);
    `CHK("comb path", 16'hf0f0, CELL_FEEDBACK_OUT)
    {CELL_REGISTERED_IN, CELL_FF_TYPE_IN, J_K_TERMS_IN} = {16'hffff, {8{2'h3}}, {8{2'h2}}, {16{2'h1}}};
    CLK_TERMS_IN = '1;
    tick(3);
    CLK_TERMS_IN = '0;
    tick(3);
    `CHK("jk sr type", 16'hf000, CELL_FEEDBACK_OUT)
    {CELL_REGISTERED_IN, PRESET_TERMS_IN} = {16'hffff, 16'hffff};
    tick(3);
    `CHK("preset", 16'hffff, CELL_FEEDBACK_OUT)
    {PRESET_TERMS_IN, CLEAR_TERMS_IN} = {16'h0000, 32'h8000_0000};
    tick(3);
    `CHK("clear", 16'h7fff, CELL_FEEDBACK_OUT)
    CLEAR_TERMS_IN = '1;
    fork
      host.wr(2'h0, 1'b0, 8'h5a);
      begin
        tick(2);
        `CHK("load wins", 8'h5a, CELL_FEEDBACK_OUT[7:0])
      end
    join
    PORT_PINS_IN = 24'ha5c31e;
    tick(1);
    `CHK("pass", 24'ha5c31e, INPUT_BUS_OUT)
    rdchk("in read", 2'h2, 2'h2, 8'ha5);
    rdchk("in read none", 2'h2, 2'h3, 8'h00);
    {IN_CELL_MODE_IN, IN_CELL_USE_STROBE_IN, PORT_PINS_IN} = {{24{2'h1}}, 6'h3f, 24'h123456};
    ADDRESS_LATCH_STROBE_IN = 1;
    tick(2);
    ADDRESS_LATCH_STROBE_IN = 0;
    tick(2);
    PORT_PINS_IN = 24'hfedcba;
    tick(2);
    `CHK("strobe latch", 24'h123456, INPUT_BUS_OUT)
    {IN_CELL_MODE_IN, IN_CELL_USE_STROBE_IN} = {{24{2'h2}}, 6'h00};
    tick(2);
    IN_CELL_CTRL_TERMS_IN = 6'h01;
    tick(3);
    `CHK("nibble reg", 24'h12345a, INPUT_BUS_OUT)
    CHIP_SEL_TERMS_IN = 3'h5;
    tick(1);
    `CHK("chip sel", 3'h5, CHIP_SELECT_OUT)
    report_and_stop;
  end
endmodule // testbench
